// ---- hdl/crtc_pkg.sv ----
/*
  Package for the CRT timing controller: register offsets, field positions,
  reset values and mode types.
  Assumes an APB slave with 32-bit data and aligned word registers.
*/
package crtc_pkg;
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_HTIME    = 8'h04;
  localparam logic [7:0] OFF_HSYNC    = 8'h08;
  localparam logic [7:0] OFF_VTIME    = 8'h0C;
  localparam logic [7:0] OFF_VSYNC    = 8'h10;
  localparam logic [7:0] OFF_START_LO = 8'h14;
  localparam logic [7:0] OFF_START_HI = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1C;
  // Mode register field positions
  localparam int MODE_EXT_BIT   = 0;
  localparam int MODE_CSYNC_BIT = 1;
  localparam int MODE_DOTW_BIT  = 2;
  localparam int MODE_HALVE_BIT = 3;
  localparam int MODE_PEL8_BIT  = 4;
  localparam int MODE_TEXT_BIT  = 5;
  localparam int MODE_SCALE_LSB = 8;
  localparam int MODE_MAXS_LSB  = 12;
  localparam int MODE_SRST_BIT  = 31;
  // Field layout of timing registers: low half and high half
  localparam int FIELD_HI_LSB   = 16;
  localparam logic [31:0] MODE_RESET  = 32'h0000_0004;
  localparam logic [31:0] HTIME_RESET = 32'h004F_005F;
  localparam logic [31:0] HSYNC_RESET = 32'h005C_0052;
  localparam logic [31:0] VTIME_RESET = 32'h01DF_020B;
  localparam logic [31:0] VSYNC_RESET = 32'h01EC_01EA;
  localparam logic [31:0] ZERO_RESET  = 32'h0000_0000;
  typedef enum logic [1:0] {CRTC_VGA_TEXT, CRTC_VGA_GFX, CRTC_EXT_GFX} crtc_mode_t;
endpackage

// ---- hdl/crtc_timing_controller.sv ----
/*
  CRT timing controller: character clock divider, horizontal and vertical
  counters, sync and blank generation and a display start address latch.
  Assumes pclk is the pixel clock (video clock) and registers are set over APB.
*/
// The register addresses and register access over APB were left to the implementer.
// Contract
// - VGA mode clocks per character: 8/9 text, doubled zoomed, 8 or 4 graphics.
// - In VGA mode the video clock is the pixel clock itself.
// - New start value applies at next horizontal retrace after upper write.
// - Composite sync enabled gives active-low composite on horizontal sync pin.
// - Each display line is scanned max scan plus one times.
// - Horizontal zoom slows pixel clock; counter then resolves 16 or 18 pixels in text, 16 or 8 in graphics.
// - Attribute processing is active only in VGA-compatible mode.
// - Mode field selects VGA-compatible or extended graphics operation.
// - Horizontal unit is a character clock, or scale-divided 8 pixels; extended mode here counts single pixels divided by scale plus one.
module crtc_timing_controller #(
  parameter int HW = 12,
  parameter int VW = 12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             hsync_n,
  output logic             vsync_n,
  output logic             blank_n,
  output logic             char_tick,
  output logic             attr_enable,
  output logic [19:0]      start_addr
);
  logic [31:0] mode_reg, mode_next, htime_reg, htime_next, hsync_reg, hsync_next;
  logic [31:0] vtime_reg, vtime_next, vsync_reg, vsync_next;
  logic [15:0] slo_reg, slo_next;
  logic [3:0]  shi_reg, shi_next;
  logic        pend_reg, pend_next;
  logic [19:0] act_reg, act_next;
  logic [4:0]  dot_reg, dot_next;
  logic [2:0]  scl_reg, scl_next;
  logic [HW-1:0] hcnt_reg, hcnt_next;
  logic [VW-1:0] vcnt_reg, vcnt_next;
  logic [4:0]  row_reg, row_next;
  logic        hs_reg, hs_next, vs_reg, vs_next, bl_reg, bl_next, tick_reg, tick_next, hsr_reg, hsr_next;
  logic        rdy_reg, rdy_next, err_reg, err_next;
  logic [31:0] rd_reg, rd_next;
  logic [4:0]  cc;
  logic        ext, access, hs_raw, vs_raw, hblk, vblk, srst, char_end, hs_start;
  crtc_pkg::crtc_mode_t mode;

  function automatic logic in_win(input logic [HW-1:0] c, input logic [HW-1:0] s, input logic [HW-1:0] e);
    in_win = (s <= e) ? (c >= s && c < e) : (c >= s || c < e);
  endfunction

  assign ext    = mode_reg[crtc_pkg::MODE_EXT_BIT];
  assign srst   = mode_reg[crtc_pkg::MODE_SRST_BIT];
  assign access = psel && penable && !rdy_reg;

  always_comb begin
    // Operating mode from the mode field
    if (ext)
      mode = crtc_pkg::CRTC_EXT_GFX;
    else if (mode_reg[crtc_pkg::MODE_TEXT_BIT])
      mode = crtc_pkg::CRTC_VGA_TEXT;
    else
      mode = crtc_pkg::CRTC_VGA_GFX;
    // Video clocks per character; pclk is the video clock
    case (mode)
      crtc_pkg::CRTC_VGA_TEXT: cc = mode_reg[crtc_pkg::MODE_DOTW_BIT] ? 5'd8 : 5'd9;
      crtc_pkg::CRTC_VGA_GFX:  cc = mode_reg[crtc_pkg::MODE_PEL8_BIT] ? 5'd4 : 5'd8;
      crtc_pkg::CRTC_EXT_GFX:  cc = 5'd1;
      default:                 cc = 5'd8;
    endcase
    if (mode != crtc_pkg::CRTC_EXT_GFX && mode_reg[crtc_pkg::MODE_HALVE_BIT])
      cc = {cc[3:0], 1'b0};
  end

  always_comb begin
    mode_next  = mode_reg;
    htime_next = htime_reg;
    hsync_next = hsync_reg;
    vtime_next = vtime_reg;
    vsync_next = vsync_reg;
    slo_next   = slo_reg;
    shi_next   = shi_reg;
    pend_next  = pend_reg;
    rdy_next   = access;
    err_next   = 1'b0;
    rd_next    = rd_reg;
    if (access) begin
      rd_next = 32'h0000_0000;
      case (paddr)
        crtc_pkg::OFF_MODE:     if (pwrite) mode_next = pwdata; else rd_next = mode_reg;
        crtc_pkg::OFF_HTIME:    if (pwrite) htime_next = pwdata; else rd_next = htime_reg;
        crtc_pkg::OFF_HSYNC:    if (pwrite) hsync_next = pwdata; else rd_next = hsync_reg;
        crtc_pkg::OFF_VTIME:    if (pwrite) vtime_next = pwdata; else rd_next = vtime_reg;
        crtc_pkg::OFF_VSYNC:    if (pwrite) vsync_next = pwdata; else rd_next = vsync_reg;
        crtc_pkg::OFF_START_LO: if (pwrite) slo_next = pwdata[15:0]; else rd_next = {16'h0000, slo_reg};
        crtc_pkg::OFF_START_HI: begin
          // Upper portion write arms the start address update
          if (pwrite) begin
            shi_next  = pwdata[3:0];
            pend_next = 1'b1;
          end else begin
            rd_next = {28'h0000000, shi_reg};
          end
        end
        crtc_pkg::OFF_STATUS:   if (!pwrite) rd_next = {{(16-VW){1'b0}}, vcnt_reg, 15'h0000, vblk};
        default:                err_next = 1'b1;
      endcase
    end
    // Latch at start of horizontal retrace; a new arm in that cycle wins
    if (clk_en && hs_start && !(access && pwrite && paddr == crtc_pkg::OFF_START_HI))
      pend_next = 1'b0;
  end

  always_comb begin
    dot_next  = dot_reg;
    scl_next  = scl_reg;
    hcnt_next = hcnt_reg;
    vcnt_next = vcnt_reg;
    row_next  = row_reg;
    act_next  = act_reg;
    char_end  = 1'b0;
    // Character unit; extended mode counts single pixels, divided by scale plus one
    if (dot_reg >= cc - 5'd1) begin
      dot_next = 5'd0;
      if (!ext || scl_reg >= mode_reg[crtc_pkg::MODE_SCALE_LSB +: 3]) begin
        scl_next = 3'd0;
        char_end = 1'b1;
      end else begin
        scl_next = scl_reg + 3'd1;
      end
    end else begin
      dot_next = dot_reg + 5'd1;
    end
    if (char_end) begin
      // Wrap at total
      if (hcnt_reg >= htime_reg[HW-1:0]) begin
        hcnt_next = '0;
        // Each line rescanned max scan plus one times
        if (row_reg >= mode_reg[crtc_pkg::MODE_MAXS_LSB +: 5]) begin
          row_next = 5'd0;
          vcnt_next = (vcnt_reg >= vtime_reg[VW-1:0]) ? '0 : vcnt_reg + 1'b1;
        end else begin
          row_next = row_reg + 5'd1;
        end
      end else begin
        hcnt_next = hcnt_reg + 1'b1;
      end
    end
    if (hs_start && pend_reg)
      act_next = {shi_reg, slo_reg};
    if (srst) begin
      // Soft reset clears the counters
      dot_next  = 5'd0;
      scl_next  = 3'd0;
      hcnt_next = '0;
      vcnt_next = '0;
      row_next  = 5'd0;
    end
  end

  assign hs_raw = in_win(hcnt_reg, hsync_reg[HW-1:0], hsync_reg[crtc_pkg::FIELD_HI_LSB +: HW]);
  assign vs_raw = in_win(vcnt_reg, vsync_reg[VW-1:0], vsync_reg[crtc_pkg::FIELD_HI_LSB +: VW]);
  assign hblk   = hcnt_reg > htime_reg[crtc_pkg::FIELD_HI_LSB +: HW];
  assign vblk   = vcnt_reg > vtime_reg[crtc_pkg::FIELD_HI_LSB +: VW];
  // Retrace start from the plain horizontal window, not the composite output
  assign hs_start = hs_raw && !hsr_reg;

  always_comb begin
    vs_next   = vs_raw;
    bl_next   = hblk || vblk;
    tick_next = char_end;
    hsr_next  = hs_raw;
    // Composite sync is active low, as the exclusive-or of both retraces
    hs_next   = mode_reg[crtc_pkg::MODE_CSYNC_BIT] ? (hs_raw ^ vs_raw) : hs_raw;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg  <= crtc_pkg::MODE_RESET;
      htime_reg <= crtc_pkg::HTIME_RESET;
      hsync_reg <= crtc_pkg::HSYNC_RESET;
      vtime_reg <= crtc_pkg::VTIME_RESET;
      vsync_reg <= crtc_pkg::VSYNC_RESET;
      slo_reg   <= '0;
      shi_reg   <= '0;
      pend_reg  <= 1'b0;
      act_reg   <= '0;
      dot_reg   <= '0;
      scl_reg   <= '0;
      hcnt_reg  <= '0;
      vcnt_reg  <= '0;
      row_reg   <= '0;
      hs_reg    <= 1'b0;
      hsr_reg   <= 1'b0;
      vs_reg    <= 1'b0;
      bl_reg    <= 1'b0;
      tick_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rd_reg    <= crtc_pkg::ZERO_RESET;
    end else if (clk_en) begin
      mode_reg  <= mode_next;
      htime_reg <= htime_next;
      hsync_reg <= hsync_next;
      vtime_reg <= vtime_next;
      vsync_reg <= vsync_next;
      slo_reg   <= slo_next;
      shi_reg   <= shi_next;
      pend_reg  <= pend_next;
      act_reg   <= act_next;
      dot_reg   <= dot_next;
      scl_reg   <= scl_next;
      hcnt_reg  <= hcnt_next;
      vcnt_reg  <= vcnt_next;
      row_reg   <= row_next;
      hs_reg    <= hs_next;
      hsr_reg   <= hsr_next;
      vs_reg    <= vs_next;
      bl_reg    <= bl_next;
      tick_reg  <= tick_next;
      rdy_reg   <= rdy_next;
      err_reg   <= err_next;
      rd_reg    <= rd_next;
    end
  end

  logic attr_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      attr_reg <= 1'b1;
    else if (clk_en)
      attr_reg <= !mode_next[crtc_pkg::MODE_EXT_BIT];
  end

  assign pready      = rdy_reg;
  assign pslverr     = err_reg;
  assign prdata      = rd_reg;
  assign hsync_n     = !hs_reg;
  assign vsync_n     = !vs_reg;
  assign blank_n     = !bl_reg;
  assign char_tick   = tick_reg;
  assign attr_enable = attr_reg;
  assign start_addr  = act_reg;

  property p_start_hold;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !hs_start) |=> $stable(act_reg);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start address changed outside retrace start");
  property p_start_load;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && hs_start && pend_reg && !srst) |=> (act_reg == $past({shi_reg, slo_reg}));
  endproperty
  a_start_load: assert property (p_start_load) else $error("start address not loaded at retrace");
  property p_attr;
    @(posedge pclk) disable iff (!presetn)
    (attr_enable == !ext);
  endproperty
  a_attr: assert property (p_attr) else $error("attribute path does not follow the mode");
  property p_csync;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && mode_reg[crtc_pkg::MODE_CSYNC_BIT]) |=> (hsync_n == !($past(hs_raw) ^ $past(vs_raw)));
  endproperty
  a_csync: assert property (p_csync) else $error("composite sync wrong");
  property p_vsync_follow;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> (vsync_n == !$past(vs_raw));
  endproperty
  a_vsync_follow: assert property (p_vsync_follow) else $error("vertical sync lost");
  property p_cc;
    @(posedge pclk) disable iff (!presetn)
    (mode == crtc_pkg::CRTC_VGA_GFX && mode_reg[crtc_pkg::MODE_PEL8_BIT] && !mode_reg[crtc_pkg::MODE_HALVE_BIT])
      |-> (cc == 5'd4);
  endproperty
  a_cc: assert property (p_cc) else $error("wrong clocks per character");
  property p_hwrap;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !srst && char_end && hcnt_reg >= htime_reg[HW-1:0]) |=> (hcnt_reg == '0);
  endproperty
  a_hwrap: assert property (p_hwrap) else $error("horizontal counter did not wrap");
  property p_srst;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && srst) |=> (hcnt_reg == '0 && vcnt_reg == '0);
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset did not clear counters");
  property p_rescan;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !srst && char_end && hcnt_reg >= htime_reg[HW-1:0] && row_reg < mode_reg[crtc_pkg::MODE_MAXS_LSB +: 5])
      |=> $stable(vcnt_reg);
  endproperty
  a_rescan: assert property (p_rescan) else $error("line advanced before rescans done");
endmodule

// ---- testbench/crtc_monitor_model.sv ----
/*
  Far-side model: a monitor that measures sync and blanking timing.
  Assumes registered sync/blank outputs changing just after pclk rising edges.
*/
module crtc_monitor_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hsync_n,
  input  wire logic vsync_n,
  input  wire logic blank_n,
  output int        line_len,
  output int        frame_len,
  output int        hs_low,
  output int        blank_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int   lc;
  int   fc;
  int   lowc;
  int   bc;
  logic hs_d;
  logic vs_d;

  // Period between sync falls, last low run, blanked cycles per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lc, fc, lowc, bc, line_len, frame_len, hs_low, blank_cnt} <= '0;
      hs_d <= 1'b1;
      vs_d <= 1'b1;
    end else begin
      hs_d <= hsync_n;
      vs_d <= vsync_n;
      lc   <= lc + 1;
      fc   <= fc + 1;
      bc   <= bc + (blank_n ? 0 : 1);
      if (!hsync_n) lowc <= lowc + 1;
      if (!hs_d && hsync_n) begin
        hs_low <= lowc;
        lowc   <= 0;
      end
      if (hs_d && !hsync_n) begin
        line_len <= lc;
        lc       <= 1;
      end
      if (vs_d && !vsync_n) begin
        frame_len <= fc;
        fc        <= 1;
        blank_cnt <= bc;
        bc        <= blank_n ? 0 : 1;
      end
    end
  end
endmodule

// ---- testbench/crtc_timing_controller_tb_top.sv ----
/*
  Self-checking bench for the CRT timing controller over APB.
  Assumes the monitor model measures line, frame, sync and blank timing.
*/
module crtc_timing_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HT = 19, HD = 11, HSS = 14, HSE = 17, VT = 9, VD = 5, VSS = 7, VSE = 9;
  localparam int L = (HT + 1) * 2, W = (HSE - HSS) * 2;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic        hsync_n, vsync_n, blank_n, char_tick, attr_enable;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, m, lo, hi, old;
  logic [19:0] start_addr;
  int          num_errors = 0, comparisons = 0, cycles = 0, n, s;
  int          line_len, frame_len, hs_low, blank_cnt;
  logic [7:0]  offs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rvals[7] = '{crtc_pkg::MODE_RESET, crtc_pkg::HTIME_RESET, crtc_pkg::HSYNC_RESET,
                            crtc_pkg::VTIME_RESET, crtc_pkg::VSYNC_RESET, crtc_pkg::ZERO_RESET,
                            crtc_pkg::ZERO_RESET};
  logic [31:0] vga[8] = '{32'h24, 32'h20, 32'h28, 32'h2C, 32'h04, 32'h0C, 32'h14, 32'h1C};

  crtc_timing_controller u_crtc_timing_controller (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .hsync_n(hsync_n), .vsync_n(vsync_n), .blank_n(blank_n),
    .char_tick(char_tick), .attr_enable(attr_enable), .start_addr(start_addr));
  crtc_monitor_model u_crtc_monitor_model (.pclk(pclk), .presetn(presetn), .hsync_n(hsync_n),
    .vsync_n(vsync_n), .blank_n(blank_n), .line_len(line_len), .frame_len(frame_len),
    .hs_low(hs_low), .blank_cnt(blank_cnt));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task end_sim;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer: setup, then access held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task sync_wait(input int k);
    @(posedge pclk);
    repeat (k) @(negedge hsync_n);
    repeat (2) @(posedge pclk);
  endtask

  task vs_wait;
    repeat (2) @(negedge vsync_n);
    repeat (2) @(posedge pclk);
  endtask

  task tick_gap(output int g);
    g = 0;
    @(posedge pclk);
    while (char_tick !== 1'b1) @(posedge pclk);
    do begin @(posedge pclk); g++; end while (char_tick !== 1'b1);
  endtask

  function automatic int exp_cc(input logic [31:0] md);
    int c;
    if (md[0]) return md[10:8] + 1;
    c = md[5] ? (md[2] ? 8 : 9) : (md[4] ? 4 : 8);
    return md[3] ? 2 * c : c;
  endfunction

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      end_sim;
    end
  end

  initial begin
    presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    void'($urandom(32'h5547d862));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk(attr_enable, 1);
    foreach (offs[i]) begin apb(0, offs[i], 0); chk(rd, rvals[i]); chk(err, 0); end
    apb(1, 8'h20, 32'hFFFF_FFFF);
    apb(0, 8'h20, 0); chk({rd[30:0], err}, 1);
    apb(1, crtc_pkg::OFF_HTIME, (HD << 16) | HT);
    apb(1, crtc_pkg::OFF_HSYNC, (HSE << 16) | HSS);
    apb(1, crtc_pkg::OFF_VTIME, (VD << 16) | VT);
    apb(1, crtc_pkg::OFF_VSYNC, (VSE << 16) | VSS);
    apb(1, crtc_pkg::OFF_MODE, 32'h101);
    chk(attr_enable, 0);
    sync_wait(3);
    chk(line_len, L);
    chk(hs_low, W);
    vs_wait();
    chk(frame_len, L * (VT + 1));
    chk(blank_cnt, L * (VT + 1) - (HD + 1) * 2 * (VD + 1));
    apb(1, crtc_pkg::OFF_MODE, 32'h3101);
    vs_wait();
    chk(frame_len, L * (VT + 1) * 4);
    apb(1, crtc_pkg::OFF_MODE, 32'h103);
    @(negedge vsync_n);
    repeat (2) @(posedge hsync_n);
    repeat (2) @(posedge pclk);
    chk(hs_low, L - W);
    for (int i = 0; i < 16; i++) begin
      s = $urandom % 8;
      if (s == 4) s = 7;
      n = $urandom;
      m = (i < 4) ? (32'h1 | (s << 8)) : (i < 12) ? vga[i - 4] :
          ((n[0] << 5) | ((n[0] ? n[1] : 1'b1) << 2) | (n[2] << 3) | ((n[0] ? 1'b0 : n[3]) << 4));
      apb(1, crtc_pkg::OFF_MODE, m);
      tick_gap(n);
      tick_gap(n);
      chk(n, exp_cc(m));
      chk(attr_enable, !m[0]);
    end
    apb(1, crtc_pkg::OFF_MODE, 32'h101);
    // Only the start address is programmed: no pitch, line offset or interlace
    for (int i = 0; i < 3; i++) begin
      lo = $urandom & 32'hFFFF_FFFE;
      hi = $urandom;
      @(negedge vsync_n);
      old = start_addr;
      apb(1, crtc_pkg::OFF_START_LO, lo);
      sync_wait(2);
      chk(start_addr, old);
      apb(1, crtc_pkg::OFF_START_HI, hi);
      sync_wait(1);
      chk(start_addr, {hi[3:0], lo[15:0]});
      apb(0, crtc_pkg::OFF_START_HI, 0); chk(rd, hi[3:0]);
    end
    @(posedge pclk) clk_en <= 1'b0;
    @(posedge pclk) m = {hsync_n, vsync_n, blank_n, char_tick, start_addr};
    repeat (100) @(posedge pclk);
    chk({hsync_n, vsync_n, blank_n, char_tick, start_addr}, m);
    clk_en <= 1'b1;
    apb(1, crtc_pkg::OFF_MODE, 32'h8000_0101);
    apb(0, crtc_pkg::OFF_STATUS, 0); chk(rd[27:16], 0);
    apb(1, crtc_pkg::OFF_MODE, 32'h101);
    sync_wait(3);
    chk(line_len, L);
    end_sim;
  end
endmodule
